// ### scrp_serial_config_port.sv
// serial configuration port with its register bank and clk-domain configuration outputs
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - serial bits shift in only while the active-low enable is low
// - input data sampled on every serial clock rising edge while enabled
// - every 24th rising edge while enabled loads the received word
// - a trailing partial word is dropped and changes no register
// - bit counter restarts at enable fall and counts groups of 24
// - word holds eight address bits then sixteen data bits; address picks register
// - port works from a few hertz up to 20 MHz, any duty cycle
// - readback drives sixteen data bits out, changing after falling edges
// - in readback only the control register stays writable
// - hardware reset pulse returns all registers to defaults
// - soft reset bit clears all registers and clears itself
// - power-down leaves all register contents unchanged
// - partial power-down bit turns the amplifier stages off; cleared by default
// - attenuation code 000 gives 18 dB, each step 3 dB less, 110 gives 0
// - narrow-band select: zero gives 75 MHz, one gives 60 MHz
// - serial gain and bandwidth apply only after reset pulsed and held low; here only serial_mode waits for it, config_out and gain_db do not
module scrp_serial_config_port
  import scrp_pkg::*;
(
  // system clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // serial link
  input  wire logic                 serial_clk,
  input  wire logic                 serial_enable_n,
  input  wire logic                 serial_data_in,
  output logic                      serial_data_out,
  // hardware reset pin, active high
  input  wire logic                 hw_reset,
  // configuration towards the analog chain
  output scrp_pkg::scrp_bank_t      config_out,
  output logic                      serial_mode,
  output logic                      amplifiers_on,
  output logic [4:0]                gain_db
);

  import scrp_pkg::*;

  // ---------------- serial clock domain ----------------

  logic [CNT_W-1:0]     bit_count;
  logic [WORD_BITS-2:0] shift_reg;
  scrp_bank_t           bank;
  scrp_bank_t           next_bank;
  logic                 update_toggle;
  logic [DATA_BITS-1:0] read_shift;
  logic                 read_bit;

  wire                  link_clear;
  wire                  word_done;
  wire                  addr_done;
  wire                  data_phase;
  wire scrp_word_t      word_now;
  wire                  hit_control;
  wire                  hit_power;
  wire                  hit_gain;
  wire                  writes_open;
  wire [DATA_BITS-1:0]  image_control;
  wire [DATA_BITS-1:0]  image_power;
  wire [DATA_BITS-1:0]  image_gain;
  wire [DATA_BITS-1:0]  read_select;
  wire [ADDR_BITS-1:0]  read_addr;

  // enable high or hardware reset holds the framing logic cleared
  assign link_clear = serial_enable_n | hw_reset;

  assign word_done  = (bit_count == CNT_LAST);
  assign addr_done  = (bit_count == CNT_ADDR);
  assign data_phase = (bit_count > CNT_ADDR);

  // newest bit enters at the bottom, so the first bit ends on top
  assign word_now = scrp_word_t'({shift_reg, serial_data_in});

  assign hit_control = (word_now.addr == ADDR_SERIAL_CONTROL);
  assign hit_power   = (word_now.addr == ADDR_POWER_DOWN);
  assign hit_gain    = (word_now.addr == ADDR_GAIN_FILTER);

  // readback blocks all but the control register
  assign writes_open = !bank.readout_enable;

  // counter restarts with every enable fall
  // a partial word is lost when the enable rises
  always_ff @(posedge serial_clk or posedge link_clear) begin
    if (link_clear) begin
      bit_count <= CNT_FIRST;
      shift_reg <= '0;
    end else begin
      shift_reg <= word_now[WORD_BITS-2:0];
      bit_count <= word_done ? CNT_FIRST : bit_count + CNT_STEP;
    end
  end

  // register write decode; only used bits are kept
  always_comb begin
    next_bank = bank;
    if (word_done) begin
      if (hit_control) begin
        next_bank.readout_enable = word_now.data[READOUT_POS];
        // soft reset clears every register, itself never stored
        if (word_now.data[SOFT_RESET_POS]) begin
          next_bank = BANK_RESET;
        end
      end else if (writes_open && hit_power) begin
        next_bank.full_power_down    = word_now.data[FULL_PDN_POS];
        next_bank.partial_power_down = word_now.data[PARTIAL_POWER_DOWN_POS];
      end else if (writes_open && hit_gain) begin
        next_bank.narrow_band_select = word_now.data[NARROW_POS];
        next_bank.attenuation_code   = word_now.data[ATTEN_MSB:ATTEN_LSB];
      end
    end
  end

  // hardware reset clears the bank even with the serial clock stopped
  // nothing but a write or a reset touches the bank
  always_ff @(posedge serial_clk or posedge hw_reset) begin
    if (hw_reset) begin
      bank          <= BANK_RESET;
      update_toggle <= 1'b0;
    end else begin
      bank          <= next_bank;
      update_toggle <= update_toggle ^ word_done;
    end
  end

  // readback images, reserved bits read zero
  assign image_control = DATA_BITS'(bank.readout_enable) << READOUT_POS;
  assign image_power   = (DATA_BITS'(bank.full_power_down) << FULL_PDN_POS)
                       | (DATA_BITS'(bank.partial_power_down) << PARTIAL_POWER_DOWN_POS);
  assign image_gain    = (DATA_BITS'(bank.narrow_band_select) << NARROW_POS)
                       | (DATA_BITS'(bank.attenuation_code) << ATTEN_LSB);

  // address is the low byte of the shifter once eight bits are in
  assign read_addr   = shift_reg[ADDR_BITS-1:0];
  assign read_select = (read_addr == ADDR_SERIAL_CONTROL) ? image_control :
                       (read_addr == ADDR_POWER_DOWN)     ? image_power   :
                       (read_addr == ADDR_GAIN_FILTER)    ? image_gain    : REG_RESET;

  // output changes on falling edges, top data bit first
  // half a serial period after the address completes, so no extra latency
  always_ff @(negedge serial_clk or posedge link_clear) begin
    if (link_clear) begin
      read_shift <= REG_RESET;
      read_bit   <= 1'b0;
    end else if (bank.readout_enable && addr_done) begin
      read_bit   <= read_select[DATA_BITS-1];
      read_shift <= read_select << 1;
    end else if (bank.readout_enable && data_phase) begin
      read_bit   <= read_shift[DATA_BITS-1];
      read_shift <= read_shift << 1;
    end else begin
      read_bit   <= 1'b0;
      read_shift <= REG_RESET;
    end
  end

  assign serial_data_out = read_bit;

  // ---------------- system clock domain ----------------

  logic       toggle_sync;
  logic       reset_sync;
  logic       toggle_seen;
  logic       reset_armed;
  logic [4:0] next_gain_db;

  wire        update_pulse;
  wire        code_valid;

  // hardware reset and word toggle each cross as a level
  scrp_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({hw_reset, update_toggle}),
    .sync_out ({reset_sync, toggle_sync})
  );

  // the bank stays still for a whole word after each toggle
  // far longer than the three system cycles the capture needs
  assign update_pulse = toggle_sync ^ toggle_seen;

  // codes above the documented range map to the floor
  assign code_valid   = (config_out.attenuation_code <= ATTEN_MAX);
  assign next_gain_db = code_valid ? GAIN_MAX_DB - GAIN_STEP_DB * {2'b00, config_out.attenuation_code}
                                   : GAIN_FLOOR_DB;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      toggle_seen <= 1'b0;
      config_out  <= BANK_RESET;
    end else begin
      toggle_seen <= toggle_sync;
      // reset pin also clears the captured copy
      if (reset_sync) begin
        config_out <= BANK_RESET;
      end else if (update_pulse) begin
        config_out <= bank;
      end
    end
  end

  // serial control only once the pin has pulsed and sits low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reset_armed <= 1'b0;
      serial_mode <= 1'b0;
    end else begin
      reset_armed <= reset_armed | reset_sync;
      serial_mode <= reset_armed & !reset_sync;
    end
  end

  // amplifiers off under either power-down bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      amplifiers_on <= 1'b1;
      gain_db       <= GAIN_MAX_DB;
    end else begin
      amplifiers_on <= !(config_out.full_power_down | config_out.partial_power_down);
      gain_db       <= next_gain_db;
    end
  end

endmodule
`default_nettype wire

// ### scrp_pkg.sv
// constants, field layout and carrier types of the serial configuration port
package scrp_pkg;

  // serial word layout, sent top bit first
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int CNT_W     = 5;

  // bit counter values: last bit of a word, address complete
  localparam logic [CNT_W-1:0] CNT_FIRST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST  = 5'h17;
  localparam logic [CNT_W-1:0] CNT_ADDR  = 5'h08;
  localparam logic [CNT_W-1:0] CNT_STEP  = 5'h01;

  // register addresses
  localparam logic [ADDR_BITS-1:0] ADDR_SERIAL_CONTROL = 8'h00;
  localparam logic [ADDR_BITS-1:0] ADDR_POWER_DOWN     = 8'h35;
  localparam logic [ADDR_BITS-1:0] ADDR_GAIN_FILTER    = 8'h3b;

  // field positions
  localparam int SOFT_RESET_POS  = 0;
  localparam int READOUT_POS     = 1;
  localparam int FULL_PDN_POS    = 15;
  localparam int PARTIAL_POWER_DOWN_POS = 14;
  localparam int NARROW_POS      = 7;
  localparam int ATTEN_LSB       = 4;
  localparam int ATTEN_MSB       = 6;

  // reset values and gain mapping
  localparam logic [DATA_BITS-1:0] REG_RESET     = 16'h0000;
  localparam logic [2:0]           ATTEN_RESET   = 3'h0;
  localparam logic [2:0]           ATTEN_MAX     = 3'h6;
  localparam logic [4:0]           GAIN_MAX_DB   = 5'h12;
  localparam logic [4:0]           GAIN_STEP_DB  = 5'h03;
  localparam logic [4:0]           GAIN_FLOOR_DB = 5'h00;

  // serial clock limits; a word lasts at least this long
  localparam int SCLK_MIN_PERIOD_NS = 50;
  localparam int CLK_PERIOD_NS      = 8;
  localparam int WORD_MIN_CYCLES    = (WORD_BITS * SCLK_MIN_PERIOD_NS) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } scrp_word_t;

  typedef struct packed {
    logic       readout_enable;
    logic       full_power_down;
    logic       partial_power_down;
    logic       narrow_band_select;
    logic [2:0] attenuation_code;
  } scrp_bank_t;

  localparam scrp_bank_t BANK_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, ATTEN_RESET};

endpackage

// ### scrp_sync.sv
// two flip-flop level synchroniser into the system clock
`timescale 1ns/1ps
`default_nettype none
module scrp_sync #(
  parameter int WIDTH = 1
) (
  // system clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // level from another domain
  input  wire logic [WIDTH-1:0] async_in,
  // level in the clk domain
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### scrp_serial_config_port_checker.sv
// concurrent checks on the serial configuration port outputs
`timescale 1ns/1ps
`default_nettype none
module scrp_serial_config_port_checker
  import scrp_pkg::*;
(
  // system clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // serial link and reset pin
  input  wire logic                 serial_clk,
  input  wire logic                 serial_enable_n,
  input  wire logic                 serial_data_in,
  input  wire logic                 serial_data_out,
  input  wire logic                 hw_reset,
  // configuration outputs
  input  wire scrp_pkg::scrp_bank_t config_out,
  input  wire logic                 serial_mode,
  input  wire logic                 amplifiers_on,
  input  wire logic [4:0]           gain_db
);
  logic [3:0] quiet_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // cycles since the last frame or pin reset; covers the 3-4 cycle crossing lag
  always_ff @(posedge clk) begin
    if (!rstn || !serial_enable_n || hw_reset) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
  end
  sequence hw_held; hw_reset [*4]; endsequence
  sequence hw_left; $fell(hw_reset) ##1 !hw_reset [*3]; endsequence
  chk_amp_follow: assert property (amplifiers_on == !($past(config_out.full_power_down) |
    $past(config_out.partial_power_down))) else $error("amplifier enable wrong");
  chk_gain_map: assert property (gain_db == (($past(config_out.attenuation_code) == 3'h7) ? 5'h00 :
    5'h12 - 5'h03 * {2'h0, $past(config_out.attenuation_code)})) else $error("gain mapping wrong");
  chk_sdo_idle: assert property (serial_enable_n && $past(serial_enable_n) |-> !serial_data_out)
    else $error("readback driven outside a frame");
  chk_sdo_gated: assert property (!serial_enable_n && !config_out.readout_enable |-> !serial_data_out)
    else $error("readback driven while disabled");
  chk_hw_clear: assert property (hw_held |=> config_out == BANK_RESET)
    else $error("pin reset did not clear bank");
  chk_mode_low: assert property (hw_reset [*3] |=> !serial_mode)
    else $error("serial mode with pin reset high");
  chk_mode_set: assert property (hw_left |-> serial_mode)
    else $error("serial mode not entered after pin reset");
  chk_cfg_quiet: assert property (quiet_cnt > 4'h8 |-> $stable(config_out))
    else $error("configuration changed without a word");
endmodule
`default_nettype wire

// ### scrp_ctl_model.sv
// behavioural serial controller facing the configuration port
`timescale 1ns/1ps
`default_nettype none
module scrp_ctl_model (
  // serial link
  output logic        serial_clk,
  output logic        serial_enable_n,
  output logic        serial_data_in,
  input  wire logic   serial_data_out,
  // readback result
  output logic [15:0] rd_data,
  output logic        rd_valid
);
  initial begin
    {serial_clk, serial_data_in, rd_valid} = 3'h0;
    serial_enable_n = 1'b1;
    rd_data = 16'h0000;
  end
  // address then data, top bit first; clock still between frames
  task automatic frame(input logic [47:0] w, input int n, input bit en, input bit rd);
    logic [15:0] r;
    r = 16'h0000;
    #3 serial_enable_n = !en;
    #10;
    for (int i = 0; i < n; i++) begin
      // bit set half a period before the rise
      serial_data_in = w[47-i];
      #15 serial_clk = 1'b1;
      // short period: take readback just before the next fall
      #15 if (i >= 8 && i < 24) r = {r[14:0], serial_data_out};
      serial_clk = 1'b0;
    end
    #10 serial_enable_n = 1'b1;
    // data line pulled down once released
    serial_data_in = 1'b0;
    #20 if (rd) begin
      rd_data = r;
      rd_valid = 1'b1;
      #1 rd_valid = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### serial_config_register_port_test.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module serial_config_register_port_test;
  import scrp_pkg::*;
  logic        clk, rstn, hw_reset, cfg_strobe, e_rd, e_full, e_part, e_nar;
  logic [2:0]  e_code;
  wire         serial_clk, serial_enable_n, serial_data_in, serial_data_out, rd_valid;
  wire         serial_mode, amplifiers_on;
  wire  [15:0] rd_data;
  wire  [4:0]  gain_db;
  scrp_bank_t  config_out;
  logic [15:0] exp_q[$];
  int          n_errors, checks, seed;
  scrp_serial_config_port dut (.clk(clk), .rstn(rstn), .serial_clk(serial_clk),
    .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .hw_reset(hw_reset), .config_out(config_out), .serial_mode(serial_mode),
    .amplifiers_on(amplifiers_on), .gain_db(gain_db));
  scrp_ctl_model ctl (.serial_clk(serial_clk), .serial_enable_n(serial_enable_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .rd_data(rd_data), .rd_valid(rd_valid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task take(input logic [15:0] got);
    if (exp_q.size() == 0) check(got, ~got);
    else check(got, exp_q.pop_front());
  endtask
  always @(posedge clk) if (cfg_strobe) take({3'h0, config_out, amplifiers_on, gain_db});
  always @(posedge rd_valid) take(rd_data);
  task apply(input logic [7:0] a, input logic [15:0] d);
    if (a == ADDR_SERIAL_CONTROL) begin
      if (d[0]) {e_rd, e_full, e_part, e_nar, e_code} = '0;
      else e_rd = d[1];
    end
    else if (!e_rd && a == ADDR_POWER_DOWN) {e_full, e_part} = d[15:14];
    else if (!e_rd && a == ADDR_GAIN_FILTER) {e_nar, e_code} = d[7:4];
  endtask
  task expect_cfg();
    repeat (8) @(posedge clk);
    exp_q.push_back({3'h0, e_rd, e_full, e_part, e_nar, e_code, !(e_full | e_part), 5'h12 - 5'h03 * {2'h0, e_code}});
    cfg_strobe <= 1'b1;
    @(posedge clk) cfg_strobe <= 1'b0;
  endtask
  // callers pass unused data bits as zero
  task wr(input logic [7:0] a, input logic [15:0] d);
    ctl.frame({a, d, 24'h0}, 24, 1'b1, 1'b0);
    apply(a, d);
    expect_cfg();
  endtask
  // readback with the write refused unless at the control register
  task rdb(input logic [7:0] a);
    logic [15:0] d;
    d = (a == ADDR_SERIAL_CONTROL) ? 16'h0002 : 16'($random(seed));
    case (a)
      ADDR_SERIAL_CONTROL: exp_q.push_back({14'h0, e_rd, 1'b0});
      ADDR_POWER_DOWN:     exp_q.push_back({e_full, e_part, 14'h0});
      ADDR_GAIN_FILTER:    exp_q.push_back({8'h0, e_nar, e_code, 4'h0});
      default:             exp_q.push_back(16'h0000);
    endcase
    ctl.frame({a, d, 24'h0}, 24, 1'b1, 1'b1);
    apply(a, d);
  endtask
  task pulse_hw();
    @(posedge clk) hw_reset <= 1'b1;
    repeat (4) @(posedge clk);
    hw_reset <= 1'b0;
    {e_rd, e_full, e_part, e_nar, e_code} = '0;
  endtask
  task end_of_test();
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    {rstn, hw_reset, cfg_strobe} = 3'h0;
    {n_errors, checks} = 0;
    seed = 7089;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    pulse_hw();
    expect_cfg();
    check(16'(serial_mode), 16'h0001);
    wr(ADDR_POWER_DOWN, 16'hc000);
    // gain codes 000 to 110 with a random bandwidth bit
    for (int c = 0; c < 7; c++) wr(ADDR_GAIN_FILTER, {8'h00, 1'($random(seed)), 3'(c), 4'h0});
    $display("test codes done");
    ctl.frame({ADDR_POWER_DOWN, 16'h4000, ADDR_GAIN_FILTER, 16'h0080}, 48, 1'b1, 1'b0);
    apply(ADDR_POWER_DOWN, 16'h4000);
    apply(ADDR_GAIN_FILTER, 16'h0080);
    expect_cfg();
    ctl.frame({ADDR_POWER_DOWN, 16'h8000, ADDR_GAIN_FILTER, 16'h0050}, 34, 1'b1, 1'b0);
    apply(ADDR_POWER_DOWN, 16'h8000);
    expect_cfg();
    // clocks with the enable high are ignored
    ctl.frame({ADDR_POWER_DOWN, 16'h0000, 24'h0}, 24, 1'b0, 1'b0);
    expect_cfg();
    $display("test framing done");
    // power-down set, contents still read back
    wr(ADDR_SERIAL_CONTROL, 16'h0002);
    for (int i = 0; i < 4; i++) rdb(8'((32'h003b3512 >> (8 * i))));
    expect_cfg();
    wr(ADDR_SERIAL_CONTROL, 16'h0000);
    $display("test readback done");
    // soft reset wins over the readback bit
    wr(ADDR_SERIAL_CONTROL, 16'h0003);
    wr(ADDR_GAIN_FILTER, 16'h00e0);
    pulse_hw();
    expect_cfg();
    $display("test resets done");
    end_of_test();
  end
endmodule
bind scrp_serial_config_port scrp_serial_config_port_checker chk (.clk(clk), .rstn(rstn),
  .serial_clk(serial_clk), .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .hw_reset(hw_reset), .config_out(config_out),
  .serial_mode(serial_mode), .amplifiers_on(amplifiers_on), .gain_db(gain_db));
`default_nettype wire
